// *** rtl/adcsf_pkg.sv ***
// Package with the register map, field positions and timing constants of the converter register block.
`default_nettype none
package adcsf_pkg;
	// Register addresses on the special function register bus.
	localparam logic [7:0] ADDR_FMT = 8'hd1;
	localparam logic [7:0] ADDR_MODE = 8'hd2;
	localparam logic [7:0] ADDR_CHP = 8'hd3;
	localparam logic [7:0] ADDR_RESH = 8'hd4;
	localparam logic [7:0] ADDR_RESL = 8'hd5;
	// Values after reset and writable bit masks.
	localparam logic [7:0] CHP_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] FMT_RST = 8'h00;
	localparam logic [7:0] CHP_WMASK = 8'hbf;
	localparam logic [7:0] FMT_WMASK = 8'he0;
	// Channel/power fields.
	localparam int PWRUP_BIT = 7;
	localparam int BUSY_BIT = 6;
	localparam int CHSEL_HI = 5;
	localparam int CHSEL_LO = 2;
	localparam int REF_HI = 1;
	localparam int REF_LO = 0;
	// Mode fields.
	localparam int DIFF_HI = 7;
	localparam int DIFF_LO = 6;
	localparam int CONT_BIT = 5;
	localparam int RATE_HI = 4;
	localparam int RATE_LO = 2;
	localparam int TACQ_HI = 1;
	localparam int TACQ_LO = 0;
	// Format fields.
	localparam int RES_HI = 7;
	localparam int RES_LO = 6;
	localparam int RLJ_BIT = 5;
	localparam int UFL_BIT = 4;
	localparam int OFL_BIT = 3;
	localparam int RNG_BIT = 2;
	// Single step power-down delay codes.
	localparam logic [1:0] PD_NONE = 2'h0;
	localparam logic [1:0] PD_6US = 2'h1;
	localparam logic [1:0] PD_24US = 2'h2;
	localparam logic [1:0] PD_INF = 2'h3;
	// Timing: clock period and documented times in picoseconds; start delay in cycles.
	localparam int CLK_PERIOD_PS = 50000;
	localparam int PD6_PS = 6000000;
	localparam int PD24_PS = 24000000;
	localparam int RATE2K_PS = 500000000;
	localparam int START_DLY_CYC = 4;
	// Least times round up to whole cycles.
	localparam int PD6_CYC = (PD6_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PD24_CYC = (PD24_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Sample period at 2 ksps; faster rates halve it per code step.
	localparam int RATE2K_CYC = RATE2K_PS / CLK_PERIOD_PS;
	// Controller states.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DELAY = 3'b001,
		ST_CONV = 3'b010,
		ST_STBY = 3'b011,
		ST_WAIT = 3'b100
	} adcsf_state_t;
	// Mask of valid result bits for a resolution code.
	function automatic logic [11:0] res_mask(input logic [1:0] resol);
		unique case (resol)
			2'h0: res_mask = 12'h03f;
			2'h1: res_mask = 12'h0ff;
			2'h2: res_mask = 12'h3ff;
			2'h3: res_mask = 12'hfff;
		endcase
	endfunction
endpackage
`default_nettype wire

// *** rtl/adcsf_align.sv ***
// Result aligner that places the conversion result in the 16-bit high:low register pair.
`timescale 1ns/1ps
`default_nettype none
module adcsf_align import adcsf_pkg::*; (
	// Stored result and format.
	input wire logic [11:0] res,
	input wire logic [1:0] resol,
	input wire logic rljust,
	// Aligned bytes.
	output logic [7:0] hi,
	output logic [7:0] lo
);
	logic [15:0] right;
	logic [15:0] left;
	logic [3:0] lshift;
	logic [15:0] pair;

	// Right alignment keeps the masked result in the lowest bits.
	assign right = {4'h0, res & res_mask(resol)};
	// Left shift is sixteen minus the resolution: 10, 8, 6 or 4.
	assign lshift = 4'ha - {1'b0, resol, 1'b0};
	assign left = right << lshift;
	// Format bit 5 picks the alignment.
	assign pair = rljust ? right : left;
	assign hi = pair[15:8];
	assign lo = pair[7:0];
endmodule // adcsf_align
`default_nettype wire

// *** rtl/adcsf_ctrl.sv ***
// Register-side controller of the successive-approximation converter with its five registers.
`timescale 1ns/1ps
`default_nettype none
module adcsf_ctrl import adcsf_pkg::*; #(
	parameter logic [13:0] RATE_BASE_CYC = 14'(RATE2K_CYC)
) (
	// Clock and synchronous reset.
	input wire logic CLK,
	input wire logic RST_B,
	// Special function register bus.
	input wire logic [7:0] SFR_ADDR,
	input wire logic [7:0] SFR_WDATA,
	input wire logic SFR_WR,
	input wire logic SFR_RD,
	output logic [7:0] SFR_RDATA,
	// Control of the analog core.
	output logic ADC_ANALOG_EN,
	output logic ADC_CORE_ON,
	output logic ADC_START,
	output logic [3:0] ADC_CHSEL,
	output logic [1:0] ADC_REFSEL,
	output logic [1:0] ADC_DIFFM,
	output logic [1:0] ADC_TACQ,
	output logic [1:0] ADC_RESOL,
	// Answer of the analog core.
	input wire logic ADC_DONE,
	input wire logic [11:0] ADC_RESULT,
	// Conversion done interrupt to the processor.
	output logic CONV_DONE_IRQ
);
	logic [7:0] chp_r;
	logic [7:0] mode_r;
	logic [7:0] fmt_r;
	adcsf_state_t state_r;
	adcsf_state_t state_nxt;
	logic [2:0] dly_r;
	logic [2:0] dly_nxt;
	logic [13:0] tmr_r;
	logic [13:0] tmr_nxt;
	logic [13:0] period;
	logic done_s1_r;
	logic done_s2_r;
	logic done_s3_r;
	logic done_lvl_r;
	logic done_evt;
	logic wr_cp;
	logic wr_mode;
	logic wr_fmt;
	logic busy;
	logic cap;
	logic start_r;
	logic irq_r;
	logic [11:0] res_r;
	logic [11:0] masked;
	logic ufl_r;
	logic ofl_r;
	logic [7:0] res_hi;
	logic [7:0] res_lo;
	logic [7:0] rd_val;
	logic [7:0] rdata_r;

	// Write strobes for the three writable registers.
	assign wr_cp = SFR_WR && (SFR_ADDR == ADDR_CHP);
	assign wr_mode = SFR_WR && (SFR_ADDR == ADDR_MODE);
	assign wr_fmt = SFR_WR && (SFR_ADDR == ADDR_FMT);

	// Channel/power register; the busy position is never stored.
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			chp_r <= CHP_RST;
		end else if (wr_cp) begin
			chp_r <= SFR_WDATA & CHP_WMASK;
		end
	end

	// Mode register holds input mode, conversion mode, rate and acquisition time.
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			mode_r <= MODE_RST;
		end else if (wr_mode) begin
			mode_r <= SFR_WDATA;
		end
	end

	// Format register keeps only resolution and alignment; flags live apart.
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			fmt_r <= FMT_RST;
		end else if (wr_fmt) begin
			fmt_r <= SFR_WDATA & FMT_WMASK;
		end
	end

	// Settings driven straight to the analog core from the registers.
	assign ADC_ANALOG_EN = chp_r[PWRUP_BIT];
	assign ADC_CHSEL = chp_r[CHSEL_HI:CHSEL_LO];
	assign ADC_REFSEL = chp_r[REF_HI:REF_LO];
	assign ADC_DIFFM = mode_r[DIFF_HI:DIFF_LO];
	assign ADC_TACQ = mode_r[TACQ_HI:TACQ_LO];
	assign ADC_RESOL = fmt_r[RES_HI:RES_LO];

	// The done pin comes from the analog domain, so it passes three flip-flops.
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			done_s1_r <= 1'b0;
			done_s2_r <= 1'b0;
			done_s3_r <= 1'b0;
			done_lvl_r <= 1'b0;
		end else begin
			done_s1_r <= ADC_DONE;
			done_s2_r <= done_s1_r;
			done_s3_r <= done_s2_r;
			if (done_s2_r == done_s3_r) begin
				done_lvl_r <= done_s3_r;
			end
		end
	end

	// A done rise counts once the second and third stages agree.
	assign done_evt = (done_s2_r == done_s3_r) && done_s3_r && !done_lvl_r;

	// Sample period for continuous mode; reserved codes fold onto the low bits.
	assign period = RATE_BASE_CYC >> mode_r[RATE_LO+1:RATE_LO];

	// Next state: start delay, conversion, standby countdown and rate wait.
	always_comb begin
		state_nxt = state_r;
		dly_nxt = (dly_r != 3'h0) ? dly_r - 3'h1 : dly_r;
		tmr_nxt = (tmr_r != 14'h0) ? tmr_r - 14'h1 : tmr_r;
		unique case (state_r)
			ST_IDLE: begin
				state_nxt = ST_IDLE;
			end
			ST_DELAY: begin
				if (dly_r == 3'h0) begin
					state_nxt = ST_CONV;
				end
			end
			ST_CONV: begin
				if (done_evt) begin
					if (mode_r[CONT_BIT]) begin
						state_nxt = ST_WAIT;
					end else begin
						unique case (mode_r[RATE_LO+1:RATE_LO])
							PD_NONE: state_nxt = ST_IDLE;
							PD_6US: begin
								state_nxt = ST_STBY;
								tmr_nxt = 14'(PD6_CYC - 1);
							end
							PD_24US: begin
								state_nxt = ST_STBY;
								tmr_nxt = 14'(PD24_CYC - 1);
							end
							PD_INF: state_nxt = ST_STBY;
						endcase
					end
				end
			end
			ST_STBY: begin
				// Infinite delay waits for software to clear power-up.
				if ((mode_r[RATE_LO+1:RATE_LO] != PD_INF) && (tmr_r == 14'h0)) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_WAIT: begin
				if (tmr_r == 14'h0) begin
					state_nxt = ST_DELAY;
					dly_nxt = 3'(START_DLY_CYC - 1);
					tmr_nxt = period - 14'h1;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		// A channel/power write overrides all, aborting any conversion under way.
		if (wr_cp) begin
			if (SFR_WDATA[PWRUP_BIT]) begin
				state_nxt = ST_DELAY;
				dly_nxt = 3'(START_DLY_CYC - 1);
				tmr_nxt = period - 14'h1;
			end else begin
				state_nxt = ST_IDLE;
			end
		end
	end

	// State and timers.
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			state_r <= ST_IDLE;
			dly_r <= 3'h0;
			tmr_r <= 14'h0;
		end else begin
			state_r <= state_nxt;
			dly_r <= dly_nxt;
			tmr_r <= tmr_nxt;
		end
	end

	// Busy covers the conversion only, from the fourth clock after the start.
	assign busy = (state_r == ST_CONV);
	assign ADC_CORE_ON = (state_r == ST_DELAY) || busy || (state_r == ST_STBY);
	// A result is taken only in a live conversion; a done of an aborted one is dropped.
	assign cap = busy && done_evt;
	assign masked = ADC_RESULT & res_mask(fmt_r[RES_HI:RES_LO]);

	// Start pulse to the core and completion interrupt.
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			start_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			start_r <= (state_r == ST_DELAY) && (dly_r == 3'h0) && !wr_cp;
			irq_r <= cap;
		end
	end
	assign ADC_START = start_r;
	assign CONV_DONE_IRQ = irq_r;

	// Result and range flags are caught together at the end of conversion.
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			res_r <= 12'h000;
			ufl_r <= 1'b0;
			ofl_r <= 1'b0;
		end else if (cap) begin
			res_r <= masked;
			ufl_r <= (masked == 12'h000);
			ofl_r <= (masked == res_mask(fmt_r[RES_HI:RES_LO]));
		end
	end

	// Alignment into the high and low result bytes.
	adcsf_align u_align (
		.res(res_r),
		.resol(fmt_r[RES_HI:RES_LO]),
		.rljust(fmt_r[RLJ_BIT]),
		.hi(res_hi),
		.lo(res_lo)
	);

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		rd_val = 8'h00;
		case (SFR_ADDR)
			ADDR_CHP: begin
				rd_val = chp_r;
				rd_val[BUSY_BIT] = busy;
			end
			ADDR_MODE: rd_val = mode_r;
			ADDR_FMT: begin
				rd_val = fmt_r;
				rd_val[UFL_BIT] = ufl_r;
				rd_val[OFL_BIT] = ofl_r;
				rd_val[RNG_BIT] = ufl_r | ofl_r;
			end
			ADDR_RESH: rd_val = res_hi;
			ADDR_RESL: rd_val = res_lo;
			default: rd_val = 8'h00;
		endcase
	end

	// Read data is registered and held until the next read.
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			rdata_r <= 8'h00;
		end else if (SFR_RD) begin
			rdata_r <= rd_val;
		end
	end
	assign SFR_RDATA = rdata_r;

	// Checks on the controller's own behaviour.
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_B);

	sequence s_start;
		wr_cp && SFR_WDATA[PWRUP_BIT];
	endsequence

	sequence s_quiet3;
		(!wr_cp)[*3];
	endsequence

	busy_low_first_a: assert property (s_start |=> !busy)
		else $error("busy high right after a starting write");
	// The start edge is the fourth after the write, so busy shows one cycle later and no write may cut in.
	busy_rise_four_a: assert property (s_start ##1 s_quiet3 ##1 !wr_cp |=> busy && ADC_START)
		else $error("busy did not rise four clocks after start");
	pwrup_follow_a: assert property (wr_cp |=> ADC_ANALOG_EN == $past(SFR_WDATA[PWRUP_BIT]))
		else $error("power-up output does not follow the written bit");
	busy_clear_a: assert property (cap && !wr_cp |=> !busy && irq_r ##1 !irq_r)
		else $error("busy or interrupt wrong at end of conversion");
	flag_range_a: assert property (cap |=> ufl_r == ($past(masked) == 12'h000))
		else $error("underflow flag does not match result");
	fmt_read_a: assert property (SFR_RD && SFR_ADDR == ADDR_FMT
		|=> SFR_RDATA[RNG_BIT] == (SFR_RDATA[UFL_BIT] | SFR_RDATA[OFL_BIT]) && SFR_RDATA[1:0] == 2'h0)
		else $error("range bit is not underflow or overflow");
	res_high_a: assert property (SFR_RD && SFR_ADDR == ADDR_RESH |=> SFR_RDATA == $past(res_hi))
		else $error("result high read wrong");
	mode_nostart_a: assert property (wr_mode && !wr_cp && state_r == ST_IDLE |=> state_r == ST_IDLE)
		else $error("mode write started a conversion");
	// A software write during the restart delay legally aborts it, so the check needs a quiet bus.
	cont_restart_a: assert property (state_r == ST_WAIT && tmr_r == 14'h0 && !wr_cp ##1 (!wr_cp)[*4]
		|=> busy && $past(state_r, 4) == ST_DELAY)
		else $error("continuous mode did not restart");
	single_off_a: assert property (cap && !wr_cp && !mode_r[CONT_BIT]
		&& mode_r[RATE_LO+1:RATE_LO] == PD_NONE |=> !ADC_CORE_ON)
		else $error("core not powered down after single conversion");
endmodule // adcsf_ctrl
`default_nettype wire

// *** testbench/adcsf_core_model.sv ***
// Behavioural model of the analog converter core that answers start pulses with a result.
`timescale 1ns/1ps
`default_nettype none
module adcsf_core_model (
	// Clock and synchronous reset.
	input wire logic clk,
	input wire logic rst_b,
	// Start request from the controller and settings from the bench.
	input wire logic start,
	input wire logic [7:0] lat,
	input wire logic [11:0] value,
	// Answer towards the controller.
	output logic done,
	output logic [11:0] result
);
	logic [7:0] cnt_r;
	logic run_r;
	logic [2:0] hold_r;

	// A start restarts the count even mid-conversion, so an old result never appears.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			run_r <= 1'b0;
			cnt_r <= 8'h00;
			done <= 1'b0;
			hold_r <= 3'h0;
		end else if (start) begin
			run_r <= 1'b1;
			cnt_r <= lat;
			done <= 1'b0;
			hold_r <= 3'h0;
		end else if (run_r && cnt_r == 8'h00) begin
			run_r <= 1'b0;
			done <= 1'b1;
			hold_r <= 3'h5;
		end else if (run_r) begin
			cnt_r <= cnt_r - 8'h01;
		end else if (hold_r != 3'h0) begin
			hold_r <= hold_r - 3'h1;
			if (hold_r == 3'h2) begin
				done <= 1'b0;
			end
		end
	end

	// Outside the hold time the result lines show the inverse, so stale data cannot pass.
	assign result = (hold_r != 3'h0) ? value : ~value;
endmodule // adcsf_core_model
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking testbench of the converter register block with an analog core model.
`timescale 1ns/1ps
`default_nettype none
module tb import adcsf_pkg::*; ;
	// Clock, reset, bus drive and observed outputs.
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata, d;
	logic an_en, core_on, start, done, irq;
	logic [3:0] chsel;
	logic [1:0] refsel, diffm, tacq, resol;
	logic [11:0] result;
	logic [7:0] lat = 8'h10;
	logic [11:0] value = 12'h000;
	logic [31:0] seed = 32'h0001_3aac;
	logic [31:0] x;
	int bad_count = 0;
	int num_checks = 0;
	int starts = 0;
	int irqs = 0;
	int pd[4] = '{0, PD6_CYC, PD24_CYC, 600};

	// The clock runs at 20 MHz.
	always #25 clk = ~clk;

	adcsf_ctrl #(.RATE_BASE_CYC(14'h0040)) u_dut (.CLK(clk), .RST_B(rst_b), .SFR_ADDR(addr), .SFR_WDATA(wdata),
		.SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .ADC_ANALOG_EN(an_en), .ADC_CORE_ON(core_on),
		.ADC_START(start), .ADC_CHSEL(chsel), .ADC_REFSEL(refsel), .ADC_DIFFM(diffm), .ADC_TACQ(tacq),
		.ADC_RESOL(resol), .ADC_DONE(done), .ADC_RESULT(result), .CONV_DONE_IRQ(irq));

	adcsf_core_model u_core (.clk(clk), .rst_b(rst_b), .start(start), .lat(lat), .value(value),
		.done(done), .result(result));

	// Start pulses and interrupt pulses are counted for the repeat and abort checks.
	always @(posedge clk) begin
		if (start === 1'b1) starts <= starts + 1;
		if (irq === 1'b1) irqs <= irqs + 1;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Expected high:low pair for a core value, resolution code and alignment.
	function automatic logic [15:0] exp_pair(input logic [11:0] v, input logic [1:0] rs, input logic rj);
		logic [15:0] m;
		m = {4'h0, v} & ((16'h0001 << (6 + 2 * rs)) - 16'h0001);
		return rj ? m : (m << (10 - 2 * rs));
	endfunction

	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		chk_bit("irq", 1'b1, irq);
	endtask

	// One single conversion with every result register and flag checked afterwards.
	task automatic conv(input logic [11:0] v, input logic [1:0] rs, input logic rj, input logic [5:0] cr);
		logic [15:0] p;
		logic uf, ov;
		p = exp_pair(v, rs, rj);
		uf = (p == 16'h0000);
		ov = (p == exp_pair(12'hfff, rs, rj));
		wr_reg(ADDR_FMT, {rs, rj, 5'h00});
		value <= v;
		lat <= 8'(8 + rnd() % 32);
		wr_reg(ADDR_CHP, {1'b1, 1'b0, cr});
		tick(3);
		chk_bit("start early", 1'b0, start);
		tick(1);
		chk_bit("start", 1'b1, start);
		chk_bit("analog en", 1'b1, an_en);
		rd_reg(ADDR_CHP, d);
		chk_byte("busy set", {2'b11, cr}, d);
		wait_irq();
		rd_reg(ADDR_CHP, d);
		chk_byte("busy clear", {2'b10, cr}, d);
		rd_reg(ADDR_FMT, d);
		chk_byte("flags", {rs, rj, uf, ov, uf | ov, 2'b00}, d);
		rd_reg(ADDR_RESH, d);
		chk_byte("result high", p[15:8], d);
		rd_reg(ADDR_RESL, d);
		chk_byte("result low", p[7:0], d);
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Main sequence: reset values, register access, conversions, power-down delays, repeats, abort.
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		for (int a = 8'hd0; a < 8'hd7; a++) begin
			rd_reg(8'(a), d);
			chk_byte("reset value", 8'h00, d);
		end
		for (int i = 0; i < 8; i++) begin
			x = rnd();
			wr_reg(ADDR_MODE, {x[7:5], 1'b0, x[3:0]});
			wr_reg(ADDR_FMT, x[15:8]);
			wr_reg(ADDR_CHP, {1'b0, x[22:16]});
			wr_reg(ADDR_RESH, x[31:24]);
			wr_reg(8'hd6, x[31:24]);
			rd_reg(ADDR_MODE, d);
			chk_byte("mode", {x[7:5], 1'b0, x[3:0]}, d);
			rd_reg(ADDR_FMT, d);
			chk_byte("format", x[15:8] & 8'he0, d);
			rd_reg(ADDR_CHP, d);
			chk_byte("channel", {2'b00, x[21:16]}, d);
			rd_reg(ADDR_RESH, d);
			chk_byte("result ro", 8'h00, d);
			rd_reg(8'hd6, d);
			chk_byte("unmapped", 8'h00, d);
			chk_byte("chan pins", {2'b00, x[21:16]}, {2'b00, chsel, refsel});
			chk_byte("mode pins", {x[7:6], x[1:0], x[15:14], 2'b00}, {diffm, tacq, resol, 2'b00});
		end
		wr_reg(ADDR_MODE, 8'h00);
		for (int i = 0; i < 12; i++) begin
			x = rnd();
			conv(i % 3 == 0 ? 12'h000 : i % 3 == 1 ? 12'hfff : x[11:0], 2'(i), i[2], x[17:12]);
		end
		for (int r = 0; r < 4; r++) begin
			wr_reg(ADDR_MODE, {4'h0, r[1:0], 2'b00});
			wr_reg(ADDR_CHP, 8'h80);
			wait_irq();
			if (r > 0) begin
				tick(pd[r] - 10);
				chk_bit("standby", 1'b1, core_on);
			end
			tick(20);
			chk_bit("powered down", r == 3, core_on);
		end
		wr_reg(ADDR_CHP, 8'h00);
		tick(3);
		chk_bit("core off", 1'b0, core_on);
		chk_bit("analog off", 1'b0, an_en);
		lat <= 8'h0a;
		wr_reg(ADDR_MODE, 8'h2c);
		starts = 0;
		wr_reg(ADDR_CHP, 8'h80);
		tick(300);
		chk_bit("fast repeat", 1'b1, starts >= 8);
		wr_reg(ADDR_CHP, 8'h00);
		wr_reg(ADDR_MODE, 8'h20);
		starts = 0;
		wr_reg(ADDR_CHP, 8'h80);
		tick(300);
		chk_bit("slow repeat", 1'b1, starts >= 4 && starts <= 5);
		wr_reg(ADDR_CHP, 8'h00);
		wr_reg(ADDR_MODE, 8'h00);
		lat <= 8'h1e;
		starts = 0;
		irqs = 0;
		wr_reg(ADDR_CHP, 8'h81);
		tick(12);
		wr_reg(ADDR_CHP, 8'h82);
		tick(120);
		chk_bit("restart count", 1'b1, starts == 2);
		chk_bit("one irq", 1'b1, irqs == 1);
		starts = 0;
		wr_reg(ADDR_MODE, 8'h01);
		wr_reg(ADDR_FMT, 8'hc0);
		tick(20);
		chk_bit("no start", 1'b1, starts == 0);
		rd_reg(ADDR_CHP, d);
		chk_byte("idle channel", 8'h82, d);
		close_out();
	end

	// Watchdog that cuts a hang short.
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		close_out();
	end
endmodule // tb
`default_nettype wire
